// ### rtl/cfg_word_pkg.sv
// Purpose: shared constants and types for the converter config word decoder
// Assumes: 12-bit word shifted msb first, 16 clocks per transfer
// Notes:   field positions follow the config word layout
package cfg_word_pkg;
    localparam int WORD_W       = 12;
    localparam int FRAME_CLKS   = 16;
    localparam int BIT_WRITE    = 11;
    localparam int BIT_SEQ_HI   = 10;
    localparam int BIT_IGN_A    = 9;
    localparam int BIT_IGN_B    = 8;
    localparam int BIT_CHAN_HI  = 7;
    localparam int BIT_CHAN_LO  = 6;
    localparam int BIT_PWR_HI   = 5;
    localparam int BIT_PWR_LO   = 4;
    localparam int BIT_SEQ_LO   = 3;
    localparam int BIT_IGN_C    = 2;
    localparam int BIT_RANGE    = 1;
    localparam int BIT_CODING   = 0;
    localparam int MUX_EDGE     = 14;
    localparam int TAG_BITS     = 2;
    // config reset: normal power, channel 0, no sequencer, ref span, binary
    localparam logic [10:0] CFG_RESET = 11'h033;

    typedef enum logic [1:0] {
        PWR_INVALID  = 2'h0,
        PWR_AUTO     = 2'h1,
        PWR_FULL_OFF = 2'h2,
        PWR_NORMAL   = 2'h3
    } pwr_mode_t;

    typedef enum logic [1:0] {
        SEQ_OFF      = 2'h0,
        SEQ_KEEP     = 2'h1,
        SEQ_CONT     = 2'h2
    } seq_mode_t;

    // seq_mode_hi at 10 combined with seq_mode_lo at 3
    function automatic seq_mode_t seq_decode(input logic hi, input logic lo);
        if (!hi)
            return SEQ_OFF;
        else if (lo)
            return SEQ_CONT;
        else
            return SEQ_KEEP;
    endfunction
endpackage

// ### rtl/link_if.sv
`timescale 1ns/1ps
// Purpose: events of the serial frame passed from the shifter to the decoder
// Assumes: all signals on clk_sys_i
// Notes:   strobes are one-cycle pulses
interface link_if;
    logic        frame_start;
    logic        word_done;
    logic [11:0] word;
    logic        mux_edge;
    logic        frame_end;
    logic [4:0]  fall_cnt;
    modport shifter (output frame_start, word_done, word, mux_edge,
                     frame_end, fall_cnt);
    modport decoder (input frame_start, word_done, word, mux_edge,
                     frame_end, fall_cnt);
endinterface

// ### rtl/serial_shifter.sv
`timescale 1ns/1ps
// Purpose: synchronise select, clock and data pins and capture the word
// Assumes: serial clock far slower than clk_sys_i
// Notes:   data sampled on falling serial clock edges
module serial_shifter
    import cfg_word_pkg::*;
(
    input  wire logic  clk_sys_i,
    input  wire logic  nrst_i,
    input  wire logic  cs_n_i,
    input  wire logic  sclk_i,
    input  wire logic  din_i,
    output logic       sclk_fall_o,
    output logic       cs_active_o,
    link_if.shifter    lnk
);
    logic [1:0] cs_s_r, sclk_s_r, din_s_r;
    logic       sclk_d_r, cs_d_r;
    logic [4:0] cnt_r;
    logic [11:0] sh_r;
    logic        done_r;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cs_s_r   <= 2'h3;
            sclk_s_r <= 2'h3;
            din_s_r  <= 2'h0;
            sclk_d_r <= 1'b1;
            cs_d_r   <= 1'b1;
        end else begin
            cs_s_r   <= {cs_s_r[0], cs_n_i};
            sclk_s_r <= {sclk_s_r[0], sclk_i};
            din_s_r  <= {din_s_r[0], din_i};
            sclk_d_r <= sclk_s_r[1];
            cs_d_r   <= cs_s_r[1];
        end
    end

    wire cs_low = ~cs_s_r[1];
    wire fall   = cs_low & sclk_d_r & ~sclk_s_r[1];
    assign sclk_fall_o       = fall;
    assign cs_active_o       = cs_low;
    assign lnk.frame_start   = cs_d_r & cs_low;
    assign lnk.frame_end     = ~cs_d_r & ~cs_low;
    wire   [4:0] cnt_nxt     = cnt_r + 5'h01;
    // only the first twelve falling edges carry config bits
    wire   take = fall && (cnt_r < 5'(WORD_W));

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_r <= 5'h00;
            sh_r  <= 12'h000;
        end else if (lnk.frame_start) begin
            cnt_r <= 5'h00;
        end else if (fall && cnt_r != 5'h1F) begin
            cnt_r <= cnt_nxt;
            if (take)
                sh_r <= {sh_r[10:0], din_s_r[1]};
        end
    end

    assign lnk.word      = sh_r;
    assign lnk.fall_cnt  = cnt_r;
    // the twelfth bit lands in sh_r on this edge, so the word is whole
    // only one cycle later; flagging it earlier would lose the last bit
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i)
            done_r <= 1'b0;
        else
            done_r <= take && cnt_nxt == 5'(WORD_W);
    end
    assign lnk.word_done = done_r;
    assign lnk.mux_edge  = fall && cnt_nxt == 5'(MUX_EDGE);

    property p_cnt_bound;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        lnk.word_done |-> cnt_r == 5'(WORD_W);
    endproperty
    a_cnt_bound: assert property (p_cnt_bound)
        else $error("word done at wrong edge");
endmodule

// ### rtl/cfg_decoder.sv
`timescale 1ns/1ps
// Purpose: hold the config word and steer mux, power, range and coding
// Assumes: shifter provides frame events on clk_sys_i
// Notes:   the 12-bit result itself comes from the converter core
module cfg_decoder
    import cfg_word_pkg::*;
#(
    parameter int WAKE_NS   = 1000,
    parameter int CLK_MHZ   = 100
)
(
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    input  wire logic        cs_n_i,
    input  wire logic        sclk_i,
    input  wire logic        din_i,
    input  wire logic [11:0] result_i,
    output logic             dout_o,
    output logic             dout_oe_o,
    output logic [1:0]       mux_chan_o,
    output logic             powered_o,
    output logic             ready_o,
    output logic             range_ref_o,
    output logic             coding_bin_o,
    output logic [1:0]       pwr_mode_o,
    output logic [1:0]       seq_mode_o,
    output logic             pwr_invalid_o
);
    localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;

    link_if lnk ();
    logic sclk_fall, cs_active;

    serial_shifter u_shift (
        .clk_sys_i  (clk_sys_i),
        .nrst_i     (nrst_i),
        .cs_n_i     (cs_n_i),
        .sclk_i     (sclk_i),
        .din_i      (din_i),
        .sclk_fall_o(sclk_fall),
        .cs_active_o(cs_active),
        .lnk        (lnk)
    );

    logic [10:0] cfg_r;
    logic [1:0]  chan_next_r;
    logic [1:0]  mux_r;
    logic [1:0]  tag_r;
    logic        seq_run_r;
    logic        pend_r;
    logic        upd_r;
    logic        off_r;
    logic [15:0] wake_r;
    logic        dout_r;
    logic [13:0] out_sh_r;

    wire       wr_en    = lnk.word[BIT_WRITE];
    wire [1:0] w_chan   = {lnk.word[BIT_CHAN_HI], lnk.word[BIT_CHAN_LO]};
    wire [1:0] w_pwr    = {lnk.word[BIT_PWR_HI], lnk.word[BIT_PWR_LO]};
    // ignored bits simply never reach the stored word
    wire [10:0] w_cfg   = {lnk.word[BIT_SEQ_HI], 2'h0,
                           lnk.word[BIT_CHAN_HI:BIT_SEQ_LO], 1'b0,
                           lnk.word[BIT_RANGE:BIT_CODING]};
    wire seq_mode_t smode = seq_decode(cfg_r[BIT_SEQ_HI],
                                       cfg_r[BIT_SEQ_LO]);
    wire [1:0] c_pwr    = {cfg_r[BIT_PWR_HI], cfg_r[BIT_PWR_LO]};
    wire [1:0] c_last   = {cfg_r[BIT_CHAN_HI], cfg_r[BIT_CHAN_LO]};
    wire       at_last  = mux_r == c_last;
    wire [1:0] seq_next = at_last ? 2'h0 : mux_r + 2'h1;

    // load one cycle after the twelfth edge, only when the write bit is set
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_r  <= CFG_RESET;
            pend_r <= 1'b0;
        end else if (lnk.word_done) begin
            pend_r <= wr_en;
            if (wr_en)
                cfg_r <= w_cfg;
        end else if (lnk.frame_start) begin
            pend_r <= 1'b0;
        end
    end

    // channel bits take effect at the end of the present conversion
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            chan_next_r <= 2'h0;
            seq_run_r   <= 1'b0;
        end else if (lnk.word_done && wr_en) begin
            chan_next_r <= w_chan;
            unique case (seq_decode(lnk.word[BIT_SEQ_HI],
                                    lnk.word[BIT_SEQ_LO]))
                SEQ_OFF:  seq_run_r <= 1'b0;
                SEQ_KEEP: seq_run_r <= seq_run_r;
                SEQ_CONT: seq_run_r <= 1'b1;
                default:  seq_run_r <= 1'b0;
            endcase
        end
    end

    logic seq_run_q;
    // a new sequence restarts at channel 0; running one steps up to the final channel, then wraps to 0
    wire [1:0] mux_nxt = (smode == SEQ_CONT && !seq_run_q) ? 2'h0 :
                         seq_run_r ? seq_next : chan_next_r;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i)
            seq_run_q <= 1'b0;
        else if (lnk.mux_edge)
            seq_run_q <= seq_run_r;
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i)
            mux_r <= 2'h0;
        else if (lnk.mux_edge)
            mux_r <= mux_nxt;
    end

    // power state: auto mode sleeps at frame end after an update
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            off_r <= 1'b0;
            upd_r <= 1'b0;
        end else begin
            if (lnk.word_done && wr_en)
                upd_r <= 1'b1;
            unique case (pwr_mode_t'(c_pwr))
                PWR_NORMAL:   off_r <= 1'b0;
                PWR_FULL_OFF: off_r <= 1'b1;
                PWR_AUTO: begin
                    if (lnk.frame_end && upd_r) begin
                        off_r <= 1'b1;
                        upd_r <= 1'b0;
                    end else if (lnk.frame_start) begin
                        off_r <= 1'b0;
                    end
                end
                PWR_INVALID:  off_r <= off_r;
            endcase
        end
    end

    // wake-up counter; ready shows when a valid conversion is possible
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i)
            wake_r <= 16'h0000;
        else if (off_r)
            wake_r <= 16'(WAKE_CYC);
        else if (wake_r != 16'h0000)
            wake_r <= wake_r - 16'h0001;
    end

    // output frame: one leading zero, two tag bits, then twelve result bits
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_sh_r <= 14'h0000;
            tag_r    <= 2'h0;
            dout_r   <= 1'b0;
        end else if (lnk.frame_start) begin
            tag_r    <= mux_r;
            out_sh_r <= {mux_r, result_i};
            dout_r   <= 1'b0;
        end else if (sclk_fall) begin
            // fourteen shifts: tag then result, zeros after
            if (lnk.fall_cnt < 5'(MUX_EDGE)) begin
                dout_r   <= out_sh_r[13];
                out_sh_r <= {out_sh_r[12:0], 1'b0};
            end else begin
                dout_r   <= 1'b0;
            end
        end
    end

    assign dout_o        = dout_r;
    assign dout_oe_o     = cs_active;
    assign mux_chan_o    = mux_r;
    assign powered_o     = ~off_r;
    assign ready_o       = ~off_r && wake_r == 16'h0000;
    assign range_ref_o   = cfg_r[BIT_RANGE];
    assign coding_bin_o  = cfg_r[BIT_CODING];
    assign pwr_mode_o    = c_pwr;
    assign seq_mode_o    = smode;
    assign pwr_invalid_o = c_pwr == PWR_INVALID;

    property p_no_write_hold;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        lnk.word_done && !wr_en |=> $stable(cfg_r);
    endproperty
    a_no_write_hold: assert property (p_no_write_hold)
        else $error("config changed without write bit");

    property p_write_load;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        lnk.word_done && wr_en |=> range_ref_o == $past(lnk.word[1])
            && coding_bin_o == $past(lnk.word[0]);
    endproperty
    a_write_load: assert property (p_write_load)
        else $error("range or coding not loaded");

    property p_mux_only_edge;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        !lnk.mux_edge |=> $stable(mux_r);
    endproperty
    a_mux_only_edge: assert property (p_mux_only_edge)
        else $error("mux moved off the fourteenth edge");

    property p_normal_on;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        c_pwr == 2'h3 ##1 c_pwr == 2'h3 |-> powered_o;
    endproperty
    a_normal_on: assert property (p_normal_on)
        else $error("powered down in normal mode");

    property p_full_off;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        c_pwr == 2'h2 ##1 c_pwr == 2'h2 |-> !powered_o;
    endproperty
    a_full_off: assert property (p_full_off)
        else $error("awake in full shutdown");

    property p_ignored;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        cfg_r[9] == 1'b0 && cfg_r[8] == 1'b0 && cfg_r[2] == 1'b0;
    endproperty
    a_ignored: assert property (p_ignored)
        else $error("ignored bits stored");

    property p_chan_latch;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        lnk.word_done && wr_en |=> chan_next_r == $past(w_chan);
    endproperty
    a_chan_latch: assert property (p_chan_latch)
        else $error("channel bits not latched");

    property p_tag;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        lnk.frame_start |=> out_sh_r[13:12] == $past(mux_r);
    endproperty
    a_tag: assert property (p_tag)
        else $error("tag does not match channel");

    property p_auto_sleep;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        c_pwr == 2'h1 && lnk.frame_end && upd_r |=> !powered_o;
    endproperty
    a_auto_sleep: assert property (p_auto_sleep)
        else $error("auto mode did not sleep after update");

    property p_upd_set;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        lnk.word_done && wr_en |=> upd_r;
    endproperty
    a_upd_set: assert property (p_upd_set)
        else $error("update not noted");

    property p_invalid_keep;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        c_pwr == 2'h0 |=> off_r == $past(off_r);
    endproperty
    a_invalid_keep: assert property (p_invalid_keep)
        else $error("invalid power bits changed power state");

    property p_wake_wait;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        off_r ##1 !off_r |-> !ready_o;
    endproperty
    a_wake_wait: assert property (p_wake_wait)
        else $error("ready without wake-up time");

    property p_seq_start;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        lnk.mux_edge && smode == SEQ_CONT && !seq_run_q |=> mux_r == 2'h0;
    endproperty
    a_seq_start: assert property (p_seq_start)
        else $error("sequence did not start at channel 0");

    property p_seq_off;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        lnk.mux_edge && !seq_run_r |=> mux_r == $past(chan_next_r);
    endproperty
    a_seq_off: assert property (p_seq_off)
        else $error("mux not on written channel");

    property p_mux_count;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        lnk.mux_edge |-> lnk.fall_cnt == 5'(MUX_EDGE - 1);
    endproperty
    a_mux_count: assert property (p_mux_count)
        else $error("mux edge not the fourteenth fall");

    property p_fmt_hold;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        !lnk.word_done |=> $stable(coding_bin_o) && $stable(range_ref_o);
    endproperty
    a_fmt_hold: assert property (p_fmt_hold)
        else $error("range or coding moved without a word");
endmodule

// ### testbench/host_port_model.sv
// Purpose: serial host that shifts one 16-clock frame and collects dout
// Assumes: link clock idles high, half period of 8 system cycles
// Notes:   link clock stands still between frames; din shows a changed
//          level while the device is not selected
`timescale 1ns/1ps
module host_port_model (
    input  wire logic        clk_sys_i,
    input  wire logic        dout_i,
    output logic             cs_n_o,
    output logic             sclk_o,
    output logic             din_o,
    output logic [15:0]      rx_o,
    output logic             done_o
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b1;
        din_o  = 1'b0;
        rx_o   = 16'h0000;
        done_o = 1'b0;
    end

    task automatic send(input logic [15:0] bits);
        @(posedge clk_sys_i);
        cs_n_o <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            din_o <= bits[i];
            repeat (8) @(posedge clk_sys_i);
            rx_o[i] = dout_i;
            sclk_o <= 1'b0;
            repeat (8) @(posedge clk_sys_i);
            sclk_o <= 1'b1;
        end
        repeat (8) @(posedge clk_sys_i);
        cs_n_o <= 1'b1;
        din_o  <= ~bits[0];
        repeat (10) @(posedge clk_sys_i);
        done_o <= 1'b1;
        @(posedge clk_sys_i);
        done_o <= 1'b0;
        // allow the wake-up time before the next frame
        repeat (100) @(posedge clk_sys_i);
    endtask
endmodule

// ### testbench/adc_config_word_decoder_tb.sv
// Purpose: self-checking bench for the config word decoder
// Assumes: one record per frame: dout stream plus config outputs
// Notes:   expected records are queued by the driver, popped by a monitor
`timescale 1ns/1ps
module adc_config_word_decoder_tb;
    import cfg_word_pkg::*;
    logic        clk_sys_i;
    logic        nrst_i;
    logic [11:0] result_r;
    logic        cs_n;
    logic        sclk;
    logic        din;
    logic        dout;
    logic [15:0] rx;
    logic        done;
    logic [1:0]  mux_chan;
    logic        range_ref;
    logic        coding_bin;
    logic [1:0]  pwr_mode;
    logic [1:0]  seq_mode;
    logic        pwr_invalid;
    logic        powered;
    logic        dout_oe;
    logic        ready;
    logic [24:0] exp_q[$];
    logic [24:0] seen;
    logic [24:0] expd;
    logic [10:0] cfg_e;
    logic [1:0]  mux_e;
    logic        pwd_e;
    int          err_count;
    int          check_count;

    cfg_decoder #(.WAKE_NS(1000), .CLK_MHZ(100)) i_dut (
        .clk_sys_i    (clk_sys_i),
        .nrst_i       (nrst_i),
        .cs_n_i       (cs_n),
        .sclk_i       (sclk),
        .din_i        (din),
        .result_i     (result_r),
        .dout_o       (dout),
        .dout_oe_o    (dout_oe),
        .mux_chan_o   (mux_chan),
        .powered_o    (powered),
        .ready_o      (ready),
        .range_ref_o  (range_ref),
        .coding_bin_o (coding_bin),
        .pwr_mode_o   (pwr_mode),
        .seq_mode_o   (seq_mode),
        .pwr_invalid_o(pwr_invalid)
    );

    host_port_model i_host (
        .clk_sys_i(clk_sys_i),
        .dout_i   (dout),
        .cs_n_o   (cs_n),
        .sclk_o   (sclk),
        .din_o    (din),
        .rx_o     (rx),
        .done_o   (done)
    );

    always #5 clk_sys_i = ~clk_sys_i;

    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // expected state advances once per frame, channel moves at edge 14
    task automatic frame(input logic [11:0] w);
        logic [11:0] res;
        logic [1:0]  tag;
        logic        was_seq;
        logic [1:0]  seq_e;
        res     = 12'($urandom);
        tag     = mux_e;
        was_seq = cfg_e[10];
        if (w[11])
            cfg_e = w[10:0];
        if (!cfg_e[10]) begin
            if (w[11])
                mux_e = cfg_e[7:6];
        end else if (cfg_e[3] && !was_seq)
            mux_e = 2'h0;
        else
            mux_e = (mux_e == cfg_e[7:6]) ? 2'h0 : mux_e + 2'h1;
        if (cfg_e[5:4] == 2'h3)
            pwd_e = 1'b1;
        else if (cfg_e[5:4] != 2'h0)
            pwd_e = 1'b0;
        seq_e = !cfg_e[10] ? 2'h0 : (cfg_e[3] ? 2'h2 : 2'h1);
        exp_q.push_back({1'b0, tag, res, mux_e, cfg_e[1], cfg_e[0],
                         cfg_e[5:4], seq_e, cfg_e[5:4] == 2'h0, pwd_e});
        result_r <= res;
        i_host.send({w, 4'($urandom)});
    endtask

    always @(posedge clk_sys_i) begin
        if (done === 1'b1) begin
            seen = {rx[15:1], mux_chan, range_ref, coding_bin, pwr_mode,
                    seq_mode, pwr_invalid, powered};
            expd = (exp_q.size() > 0) ? exp_q.pop_front() : 25'h0;
            check_count++;
            if (seen !== expd) begin
                err_count++;
                $display("MISMATCH frame record expected %h seen %h",
                         expd, seen);
            end
            check_count++;
            if (dout_oe !== 1'b0 || (powered !== 1'b1 && ready !== 1'b0)) begin
                err_count++;
                $display("MISMATCH oe_ready expected 00 seen %b%b",
                         dout_oe, ready);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        err_count++;
        print_verdict();
    end

    initial begin
        clk_sys_i   = 1'b0;
        nrst_i      = 1'b0;
        result_r    = 12'h000;
        err_count   = 0;
        check_count = 0;
        cfg_e       = 11'h033;
        mux_e       = 2'h0;
        pwd_e       = 1'b1;
        void'($urandom(32'hC54D));
        repeat (4) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (5) @(posedge clk_sys_i);
        frame({1'b0, 11'($urandom)});
        for (int c = 0; c < 4; c++) begin
            // power bits fixed at 11: random words never pick pattern 00
            frame({2'h2, 2'($urandom), 2'(c), 2'h3, 2'($urandom) & 2'h1,
                   2'($urandom)});
        end
        frame({1'b0, 11'($urandom)});
        frame(12'h860);
        frame({1'b0, 11'h7FF});
        frame(12'h8F3);
        frame(12'h853);
        frame(12'h853);
        frame(12'h8B3);
        frame(12'h883);
        frame(12'h8B3);
        frame(12'hCBB);
        repeat (4) frame({1'b0, 11'($urandom)});
        frame(12'hCB2);
        frame(12'h8F3);
        repeat (3) @(posedge clk_sys_i);
        if (exp_q.size() != 0) begin
            err_count++;
            $display("MISMATCH pending records expected 0 seen %0d",
                     exp_q.size());
        end
        print_verdict();
    end
endmodule
